/* File: gam_monitor.sv */
// Function
// [R1] threshold accepted only within 1..100% full scale
// [R2] high and low alarm directions supported
// [R3] high: trip above threshold+band, release below threshold-band; code also trips at threshold+band
// [R4] low: trip below threshold-band, release above threshold+band; code also trips at threshold-band
// [R5] dead band resets to zero
// [R6] dwell time 0..30 seconds, one second steps
// [R7] alarm only after condition held full dwell
// [R8] relay follows alarm only when relay enabled
// [R9] E-10 cartridge missing or defective
// [R10] E-11 cartridge communication lost
// [R11] E-12 no gas sensor in cartridge
// [R12] E-13 sensor board memory defective
// [R13] E-14 sensor self-test defective
// [R14] E-20 flow sensor not running
// [R15] E-21 flow below 0%, E-22 above 120%
// [R16] E-23 flow below 250 ml when enabled
// [R17] E-30 pyrolyzer current below 50 mA
// [R18] E-31 main memory not detected
// [R19] E-32 pyrolyzer current above 900 mA
// [R20] E-34 measurement hunting continuously
// [R21] W-01 calibration period expired
// [R22] W-02 manufacture date not entered
// [R23] status bit1 alarm, bit2 fault, bit7 heartbeat
// [R24] evaluate per update, one second dwell tick
//
// The Wishbone slave port and the address map were decided locally.
`include "gam_params.svh"

module gam_monitor
	import gam_pkg::*;
#(
	parameter int TICK_CYCLES = `GAM_TICK_CYCLES,
	parameter int HUNT_LIMIT = `GAM_HUNT_LIMIT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic measValid,
	input wire gam_meas_s meas,
	input wire gam_pins_s pins,
	output logic relayOut,
	output logic alarmActive,
	output logic faultActive,
	output logic warnActive
);
	if (TICK_CYCLES < 2) begin : g_badTick
		$error("tick period must be at least two cycles");
	end

	// byte-lane merge of a write into an old register value
	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// threshold must lie between 1% and 100% of full scale
	function automatic logic thrInRange(input logic [15:0] thr,
		input logic [15:0] fs);
		logic [23:0] t100;
		logic [23:0] lo;
		logic [23:0] hi;
		t100 = 24'(thr) * 24'h000064;
		lo = 24'(fs) * 24'(`GAM_PCT_MIN);
		hi = 24'(fs) * 24'(`GAM_PCT_MAX);
		return (t100 >= lo) && (t100 <= hi) && (thr != 16'h0000);
	endfunction

	// fault number shown to software, lowest active bit wins
	function automatic logic [7:0] codeOf(input gam_fault_t f);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 17; i >= 0; i--) begin
			if (f[i]) begin
				case (i)
					`GAM_F_E10: c = 8'h10;
					`GAM_F_E11: c = 8'h11;
					`GAM_F_E12: c = 8'h12;
					`GAM_F_E13: c = 8'h13;
					`GAM_F_E14: c = 8'h14;
					`GAM_F_E20: c = 8'h20;
					`GAM_F_E21: c = 8'h21;
					`GAM_F_E22: c = 8'h22;
					`GAM_F_E23: c = 8'h23;
					`GAM_F_E30: c = 8'h30;
					`GAM_F_E31: c = 8'h31;
					`GAM_F_E32: c = 8'h32;
					`GAM_F_E34: c = 8'h34;
					`GAM_F_W01: c = 8'h81;
					`GAM_F_W02: c = 8'h82;
					default: c = c;
				endcase
			end
		end
		return c;
	endfunction

	gam_ctrl_s ctrl_reg; // control bits
	logic [15:0] thr_reg; // alarm_level_two_setting
	logic [15:0] band_reg; // dead band
	logic [4:0] dwell_reg; // alarm_two_dwell_setting, seconds
	logic [15:0] fscale_reg; // full-scale concentration
	logic ack_reg; // bus answer
	logic [31:0] datOut_reg; // read data
	gam_pins_s pinsMeta_reg; // first synchroniser stage
	gam_pins_s pinsSync_reg; // second stage, the only one read
	gam_meas_s meas_reg; // last measurement update
	logic trip_reg; // trip condition at last update
	logic release_reg; // release condition at last update
	gam_alm_e alm_reg; // alarm qualification state
	logic [4:0] dwellCnt_reg; // seconds the trip has held
	logic [31:0] tickCnt_reg; // cycle counter for the tick
	logic tick_reg; // one-cycle pulse each second
	logic [1:0] beatCnt_reg; // seconds since last heartbeat flip
	logic beat_reg; // heartbeat
	gam_fault_t fault_reg; // fault and warning vector
	logic relay_reg; // relay drive
	logic hunting; // from hunt detector
	logic busReq; // request seen this cycle
	logic busWr; // write takes effect this edge
	logic [31:0] wrThr; // merged threshold write
	logic [31:0] statusWord; // assembled status
	logic [17:0] upper; // threshold plus band
	logic signed [17:0] lower; // threshold minus band
	logic [17:0] concW; // concentration widened

	// classic wishbone slave: answer one cycle after the request
	assign busReq = cyc_i && stb_i && !ack_reg;
	assign busWr = cyc_i && stb_i && we_i && ack_reg;
	assign ack_o = ack_reg;
	assign dat_o = datOut_reg;
	assign wrThr = laneMerge({16'h0000, thr_reg}, dat_i, sel_i);

	// ack toggles, so a held request is answered every other cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= busReq;
		end
	end

	// status word shown to software
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[`GAM_ST_ALARM] = (alm_reg == GAM_ALARM); // [R23]
		statusWord[`GAM_ST_FAULT] = |fault_reg[12:0]; // [R23]
		statusWord[`GAM_ST_BEAT] = beat_reg; // [R23]
		statusWord[`GAM_ST_RELAY] = relay_reg;
		statusWord[`GAM_ST_WARN] = |fault_reg[17:16];
	end

	// read data captured in the request cycle, held with the ack
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			datOut_reg <= 32'h0000_0000;
		end else if (busReq && !we_i) begin
			if (adr_i == `GAM_ADR_CTRL) begin
				datOut_reg <= {29'h0, ctrl_reg};
			end else if (adr_i == `GAM_ADR_THRESH) begin
				datOut_reg <= {16'h0000, thr_reg};
			end else if (adr_i == `GAM_ADR_DEADBAND) begin
				datOut_reg <= {16'h0000, band_reg};
			end else if (adr_i == `GAM_ADR_DWELL) begin
				datOut_reg <= {27'h0, dwell_reg};
			end else if (adr_i == `GAM_ADR_FSCALE) begin
				datOut_reg <= {16'h0000, fscale_reg};
			end else if (adr_i == `GAM_ADR_STATUS) begin
				datOut_reg <= statusWord;
			end else if (adr_i == `GAM_ADR_FAULTS) begin
				datOut_reg <= {14'h0, fault_reg};
			end else if (adr_i == `GAM_ADR_CODE) begin
				datOut_reg <= {24'h0, codeOf(fault_reg)};
			end else begin
				datOut_reg <= 32'h0000_0000; // unmapped reads zero
			end
		end
	end

	// settings: written at the edge where ack is high
	always_ff @(posedge clk) begin
		logic [31:0] m;
		m = 32'h0000_0000;
		if (!rst_n) begin
			ctrl_reg <= '0;
			thr_reg <= `GAM_RST_THRESH;
			band_reg <= `GAM_RST_DEADBAND; // [R5]
			dwell_reg <= `GAM_RST_DWELL;
			fscale_reg <= `GAM_RST_FSCALE;
		end else if (busWr) begin
			if (adr_i == `GAM_ADR_CTRL) begin
				m = laneMerge({29'h0, ctrl_reg}, dat_i, sel_i);
				ctrl_reg <= m[2:0];
			end else if (adr_i == `GAM_ADR_THRESH) begin
				// out-of-range values are dropped, old one stays
				if (thrInRange(wrThr[15:0], fscale_reg)) begin // [R1]
					thr_reg <= wrThr[15:0];
				end
			end else if (adr_i == `GAM_ADR_DEADBAND) begin
				m = laneMerge({16'h0000, band_reg}, dat_i, sel_i);
				band_reg <= m[15:0];
			end else if (adr_i == `GAM_ADR_DWELL) begin
				m = laneMerge({27'h0, dwell_reg}, dat_i, sel_i);
				if (m[31:5] == 27'h0 && m[4:0] <= `GAM_DWELL_MAX) begin
					dwell_reg <= m[4:0]; // [R6]
				end
			end else if (adr_i == `GAM_ADR_FSCALE) begin
				m = laneMerge({16'h0000, fscale_reg}, dat_i, sel_i);
				fscale_reg <= m[15:0];
			end
		end
	end

	// pin levels cross into the clock domain through two flops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinsMeta_reg <= '0;
			pinsSync_reg <= '0;
		end else begin
			pinsMeta_reg <= pins;
			pinsSync_reg <= pinsMeta_reg;
		end
	end

	// one second tick and the two second heartbeat
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tickCnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
		end else if (tickCnt_reg == 32'(TICK_CYCLES - 1)) begin
			tickCnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b1; // [R24]
		end else begin
			tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
			tick_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			beatCnt_reg <= 2'h0;
			beat_reg <= 1'b0;
		end else if (tick_reg) begin
			if (beatCnt_reg == 2'(`GAM_BEAT_SEC - 1)) begin
				beatCnt_reg <= 2'h0;
				beat_reg <= !beat_reg; // [R23]
			end else begin
				beatCnt_reg <= beatCnt_reg + 2'h1;
			end
		end
	end

	// hysteresis limits; lower limit goes below zero when band exceeds threshold, compared with signed math
	assign upper = 18'(thr_reg) + 18'(band_reg);
	assign lower = $signed(18'(thr_reg)) - $signed(18'(band_reg));
	assign concW = 18'(meas.conc);

	// conditions sampled only on a measurement update
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meas_reg <= '0;
			trip_reg <= 1'b0;
			release_reg <= 1'b0;
		end else if (measValid) begin // [R24]
			meas_reg <= meas;
			if (!ctrl_reg.lowDirectionMode) begin // [R2]
				trip_reg <= concW >= upper; // [R3]
				release_reg <= $signed(concW) < lower; // [R3]
			end else begin
				trip_reg <= $signed(concW) <= lower; // [R4]
				release_reg <= concW > upper; // [R4]
			end
		end
	end

	// alarm qualification: a trip must hold for the whole dwell
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alm_reg <= GAM_IDLE;
			dwellCnt_reg <= 5'h00;
		end else begin
			case (alm_reg)
				GAM_IDLE: begin
					dwellCnt_reg <= 5'h00;
					if (trip_reg) begin
						alm_reg <= GAM_QUALIFY;
					end
				end
				GAM_QUALIFY: begin
					// trip lost early: start again from zero
					if (!trip_reg) begin
						alm_reg <= GAM_IDLE; // [R7]
					end else if (dwellCnt_reg >= dwell_reg) begin
						alm_reg <= GAM_ALARM; // [R7]
					end else if (tick_reg) begin
						dwellCnt_reg <= dwellCnt_reg + 5'h01;
					end
				end
				GAM_ALARM: begin
					if (release_reg) begin
						alm_reg <= GAM_IDLE; // [R3] [R4]
					end
				end
				default: alm_reg <= GAM_IDLE;
			endcase
		end
	end

	// relay only when contact output is switched on
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			relay_reg <= 1'b0;
		end else begin
			relay_reg <= ctrl_reg.alarmTwoRelaySetting &&
				(alm_reg == GAM_ALARM); // [R8]
		end
	end

	gam_hunt_detect #(
		.WIDTH(16),
		.LIMIT(HUNT_LIMIT)
	) u_hunt (
		.clk(clk),
		.rst_n(rst_n),
		.sampleValid(measValid),
		.sample(meas.conc),
		.hunting(hunting)
	);

	// fault and warning vector, levels, no latching
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fault_reg <= '0;
		end else begin
			fault_reg <= '0;
			fault_reg[`GAM_F_E10] <= pinsSync_reg.cartMissing ||
				pinsSync_reg.cartDefect; // [R9]
			fault_reg[`GAM_F_E11] <= pinsSync_reg.cartCommLost; // [R10]
			fault_reg[`GAM_F_E12] <= pinsSync_reg.sensorMissing; // [R11]
			fault_reg[`GAM_F_E13] <= pinsSync_reg.sensorNvmBad; // [R12]
			fault_reg[`GAM_F_E14] <= pinsSync_reg.selfTestBad; // [R13]
			fault_reg[`GAM_F_E20] <= pinsSync_reg.flowSensorStopped; // [R14]
			fault_reg[`GAM_F_E21] <= meas_reg.flowPct < 16'sh0000; // [R15]
			fault_reg[`GAM_F_E22] <=
				meas_reg.flowPct > `GAM_FLOW_HIGH_PCT; // [R15]
			fault_reg[`GAM_F_E23] <= ctrl_reg.lowFlowCheckEnable &&
				(meas_reg.flowMl < `GAM_LOWFLOW_ML); // [R16]
			fault_reg[`GAM_F_E30] <= meas_reg.pyroMa < `GAM_PYRO_LOW_MA; // [R17]
			fault_reg[`GAM_F_E31] <= pinsSync_reg.mainNvmMissing; // [R18]
			fault_reg[`GAM_F_E32] <=
				meas_reg.pyroMa > `GAM_PYRO_HIGH_MA; // [R19]
			fault_reg[`GAM_F_E34] <= hunting; // [R20]
			fault_reg[`GAM_F_W01] <= pinsSync_reg.calExpired; // [R21]
			fault_reg[`GAM_F_W02] <= pinsSync_reg.mfgDateMissing; // [R22]
		end
	end

	assign relayOut = relay_reg;
	assign alarmActive = (alm_reg == GAM_ALARM);
	assign faultActive = |fault_reg[12:0];
	assign warnActive = |fault_reg[17:16];

	// checks beside the logic
	property p_thrRefuse;
		@(posedge clk) disable iff (!rst_n)
		busWr && adr_i == `GAM_ADR_THRESH &&
			!thrInRange(wrThr[15:0], fscale_reg) |=> $stable(thr_reg);
	endproperty
	a_thrRefuse: assert property (p_thrRefuse) else // [R1]
		$error("out-of-range threshold was accepted");

	property p_bandReset;
		@(posedge clk) $rose(rst_n) |-> band_reg == 16'h0000;
	endproperty
	a_bandReset: assert property (p_bandReset) else // [R5]
		$error("dead band not zero after reset");

	property p_dwellMax;
		@(posedge clk) disable iff (!rst_n) dwell_reg <= `GAM_DWELL_MAX;
	endproperty
	a_dwellMax: assert property (p_dwellMax) else // [R6]
		$error("dwell above thirty seconds");

	property p_dwellHeld;
		@(posedge clk) disable iff (!rst_n)
		$rose(alm_reg == GAM_ALARM) |->
			$past(trip_reg) && $past(dwellCnt_reg) >= $past(dwell_reg);
	endproperty
	a_dwellHeld: assert property (p_dwellHeld) else // [R7]
		$error("alarm raised before dwell elapsed");

	property p_relayGate;
		@(posedge clk) disable iff (!rst_n)
		relayOut |-> $past(ctrl_reg.alarmTwoRelaySetting) &&
			$past(alm_reg == GAM_ALARM);
	endproperty
	a_relayGate: assert property (p_relayGate) else // [R8]
		$error("relay driven while disabled or idle");

	property p_highTrip;
		@(posedge clk) disable iff (!rst_n)
		measValid && !ctrl_reg.lowDirectionMode && concW >= upper
			|=> trip_reg;
	endproperty
	a_highTrip: assert property (p_highTrip) else // [R3]
		$error("high trip not detected");

	property p_lowRelease;
		@(posedge clk) disable iff (!rst_n)
		measValid && ctrl_reg.lowDirectionMode && concW > upper
			|=> release_reg ##1 alm_reg != GAM_ALARM;
	endproperty
	a_lowRelease: assert property (p_lowRelease) else // [R4]
		$error("low alarm not released");

	property p_flowHigh;
		@(posedge clk) disable iff (!rst_n)
		measValid && meas.flowPct > `GAM_FLOW_HIGH_PCT
			|=> ##1 fault_reg[`GAM_F_E22] && faultActive;
	endproperty
	a_flowHigh: assert property (p_flowHigh) else // [R15]
		$error("flow above limit without fault");

	property p_lowFlowOff;
		@(posedge clk) disable iff (!rst_n)
		!ctrl_reg.lowFlowCheckEnable |=> !fault_reg[`GAM_F_E23];
	endproperty
	a_lowFlowOff: assert property (p_lowFlowOff) else // [R16]
		$error("low flow fault while check disabled");

	property p_beatOnTick;
		@(posedge clk) disable iff (!rst_n)
		$changed(beat_reg) |-> $past(tick_reg);
	endproperty
	a_beatOnTick: assert property (p_beatOnTick) else // [R23]
		$error("heartbeat flipped off the tick");

	c_alarm: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(alm_reg == GAM_ALARM));
	c_abort: cover property (@(posedge clk) disable iff (!rst_n)
		alm_reg == GAM_QUALIFY ##1 alm_reg == GAM_IDLE);
	c_relay: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(relayOut));
	c_hunt: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(fault_reg[`GAM_F_E34]));
endmodule // gam_monitor

/* File: gam_params.svh */
`ifndef GAM_PARAMS_SVH
`define GAM_PARAMS_SVH

// register byte offsets on the wishbone bus
`define GAM_ADR_CTRL 8'h00
`define GAM_ADR_THRESH 8'h04
`define GAM_ADR_DEADBAND 8'h08
`define GAM_ADR_DWELL 8'h0c
`define GAM_ADR_FSCALE 8'h10
`define GAM_ADR_STATUS 8'h14
`define GAM_ADR_FAULTS 8'h18
`define GAM_ADR_CODE 8'h1c

// control register field positions
`define GAM_CTRL_RELAY 0
`define GAM_CTRL_LOWDIR 1
`define GAM_CTRL_LOWFLOW 2

// status register field positions
`define GAM_ST_ALARM 1
`define GAM_ST_FAULT 2
`define GAM_ST_BEAT 7
`define GAM_ST_RELAY 8
`define GAM_ST_WARN 9

// fault vector bit positions, warnings in the upper part
`define GAM_F_E10 0
`define GAM_F_E11 1
`define GAM_F_E12 2
`define GAM_F_E13 3
`define GAM_F_E14 4
`define GAM_F_E20 5
`define GAM_F_E21 6
`define GAM_F_E22 7
`define GAM_F_E23 8
`define GAM_F_E30 9
`define GAM_F_E31 10
`define GAM_F_E32 11
`define GAM_F_E34 12
`define GAM_F_W01 16
`define GAM_F_W02 17

// reset values
`define GAM_RST_THRESH 16'h0014
`define GAM_RST_DEADBAND 16'h0000
`define GAM_RST_DWELL 5'h00
`define GAM_RST_FSCALE 16'h0064

// limits and levels
`define GAM_DWELL_MAX 5'h1e
`define GAM_PCT_MIN 8'h01
`define GAM_PCT_MAX 8'h64
`define GAM_FLOW_HIGH_PCT 16'sh0078
`define GAM_LOWFLOW_ML 16'h00fa
`define GAM_PYRO_LOW_MA 16'h0032
`define GAM_PYRO_HIGH_MA 16'h0384

// timing: one second tick, heartbeat half period in seconds
`define GAM_CLK_PERIOD_NS 8
`define GAM_TICK_SEC 1
`define GAM_TICK_CYCLES (`GAM_TICK_SEC * 1000000000 / `GAM_CLK_PERIOD_NS)
`define GAM_BEAT_SEC 2
`define GAM_HUNT_LIMIT 8

`endif

/* File: gam_pkg.sv */
package gam_pkg;

	// one measurement update from the sampling path
	typedef struct packed {
		logic [15:0] conc; // gas concentration, raw units
		logic signed [15:0] flowPct; // flow in percent of nominal
		logic [15:0] flowMl; // flow in ml
		logic [15:0] pyroMa; // pyrolyzer current in mA
	} gam_meas_s;

	// status levels from cartridge and main board, asynchronous
	typedef struct packed {
		logic cartMissing;
		logic cartDefect;
		logic cartCommLost;
		logic sensorMissing;
		logic sensorNvmBad;
		logic selfTestBad;
		logic flowSensorStopped;
		logic mainNvmMissing;
		logic calExpired;
		logic mfgDateMissing;
	} gam_pins_s;

	// software control bits
	typedef struct packed {
		logic lowFlowCheckEnable; // low_flow_check_enable
		logic lowDirectionMode; // 1 low_direction_mode, 0 high
		logic alarmTwoRelaySetting; // relay on/off
	} gam_ctrl_s;

	// alarm qualification states
	typedef enum logic [1:0] {
		GAM_IDLE,
		GAM_QUALIFY,
		GAM_ALARM
	} gam_alm_e;

	typedef logic [17:0] gam_fault_t;

endpackage : gam_pkg

/* File: gam_hunt_detect.sv */
`include "gam_params.svh"

// flags a measurement that keeps reversing direction on each update
module gam_hunt_detect
	import gam_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int LIMIT = `GAM_HUNT_LIMIT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sampleValid,
	input wire logic [WIDTH-1:0] sample,
	output logic hunting
);
	if (LIMIT < 2 || LIMIT > 255) begin : g_badLimit
		$error("hunt limit must be 2..255");
	end

	logic [WIDTH-1:0] prevSample_reg; // last sample seen
	logic [1:0] prevDir_reg; // 0 flat, 1 up, 2 down
	logic [7:0] revCount_reg; // consecutive reversals
	logic [1:0] dirNow;
	logic reversal;

	// direction of this step compared to the previous sample
	always_comb begin
		if (sample > prevSample_reg) begin
			dirNow = 2'h1;
		end else if (sample < prevSample_reg) begin
			dirNow = 2'h2;
		end else begin
			dirNow = 2'h0;
		end
		reversal = (dirNow != 2'h0) && (prevDir_reg != 2'h0) &&
			(dirNow != prevDir_reg);
	end

	// a single non-reversing step breaks the run: only steady hunting counts
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prevSample_reg <= '0;
			prevDir_reg <= 2'h0;
			revCount_reg <= 8'h00;
		end else if (sampleValid) begin
			prevSample_reg <= sample;
			prevDir_reg <= dirNow;
			if (!reversal) begin
				revCount_reg <= 8'h00;
			end else if (revCount_reg != 8'hff) begin
				revCount_reg <= revCount_reg + 8'h01;
			end
		end
	end

	assign hunting = (revCount_reg >= 8'(LIMIT));
endmodule // gam_hunt_detect

/* File: gam_far_side.sv */
// far side: sampling head that posts one update every fourth cycle
module gam_far_side
	import gam_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire gam_meas_s measIn,
	input wire gam_pins_s pinsIn,
	output logic measValid,
	output gam_meas_s meas,
	output gam_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_reg; // update cadence counter

	// cadence and data; data is scrambled between updates so the
	// block cannot lean on a stale value
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_reg <= 2'h0;
			measValid <= 1'b0;
			meas <= '0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			measValid <= (phase_reg == 2'h3);
			meas <= (phase_reg == 2'h3) ? measIn : ~measIn;
		end
	end

	// cartridge and board status are plain levels
	assign pins = pinsIn;
endmodule // gam_far_side

/* File: gas_alarm_and_fault_monitor_test.sv */
`include "gam_params.svh"

module gas_alarm_and_fault_monitor_test
	import gam_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, cyc_i, stb_i, we_i, ack_o, measValid;
	logic relayOut, alarmActive, faultActive, warnActive;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	gam_meas_s measIn, meas;
	gam_pins_s pinsIn, pins;
	int nMismatch = 0, checkCount = 0;
	logic [31:0] expQ[$], mskQ[$]; // pending read notes
	logic [31:0] rdData; // read word taken at the ack edge
	logic [15:0] rnd = 16'h4e9d; // lfsr state
	int pinBit[10] = '{0, 0, 1, 2, 3, 4, 5, 10, 16, 17};
	logic [15:0] fpT[7] = '{16'hffff, 16'h0079, 16'h0078, 16'h0064,
		16'h0064, 16'h0064, 16'h0064};
	logic [15:0] mlT[7] = '{500, 500, 500, 249, 250, 500, 500};
	logic [15:0] pyT[7] = '{100, 100, 100, 100, 49, 901, 900};
	logic [31:0] fxT[7] = '{32'h40, 32'h80, 0, 32'h100, 32'h200, 32'h800, 0};
	logic [15:0] hiC[5] = '{21, 22, 19, 17, 18};
	logic hiA[5] = '{0, 1, 1, 0, 0};
	logic [15:0] loC[6] = '{30, 19, 18, 21, 23, 22};
	logic loA[6] = '{0, 0, 1, 1, 0, 0};

	gam_monitor #(.TICK_CYCLES(20), .HUNT_LIMIT(8)) u_dut (.clk(clk),
		.rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .measValid(measValid), .meas(meas), .pins(pins),
		.relayOut(relayOut), .alarmActive(alarmActive),
		.faultActive(faultActive), .warnActive(warnActive));
	gam_far_side u_far (.clk(clk), .rst_n(rst_n), .measIn(measIn),
		.pinsIn(pinsIn), .measValid(measValid), .meas(meas), .pins(pins));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic wrapUp();
		// a read note never answered counts as a miss
		if (expQ.size() != 0) begin
			nMismatch++;
		end
		if (nMismatch == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] s, e);
		checkCount++;
		if (s !== e) begin
			nMismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// next state of the 16-bit stimulus lfsr
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// classic single cycle; hold until ack, then idle one cycle
	task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk);
		while (!ack_o && n < 16) begin
			@(posedge clk);
			n++;
		end
		if (n >= 16) begin
			nMismatch++;
			wrapUp();
		end
		rdData = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, logic [31:0] m, e);
		mskQ.push_back(m);
		expQ.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	// two fresh updates, then the documented output latency
	task automatic settle();
		int n;
		n = 0;
		repeat (2) begin
			@(posedge clk);
			while (!measValid && n < 40) begin
				@(posedge clk);
				n++;
			end
		end
		if (n >= 40) begin
			nMismatch++;
			wrapUp();
		end
		repeat (4) @(posedge clk);
	endtask

	task automatic upd(input logic [15:0] c);
		measIn.conc <= c;
		settle();
	endtask

	// watcher: oldest note is matched against each read answer
	always @(posedge clk) begin
		if (ack_o && !we_i && expQ.size() > 0)
			check("read data", dat_o & mskQ.pop_front(), expQ.pop_front());
	end

	initial begin
		rst_n = 1'b0;
		{cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		sel_i = 4'hf;
		measIn = '{16'h0, 16'sh64, 16'd500, 16'd100};
		pinsIn = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`GAM_ADR_THRESH, 32'hffff, 32'h14);
		rd(`GAM_ADR_DEADBAND, 32'hffff, 32'h0);
		rd(8'h20, 32'hffffffff, 32'h0);
		bus(1'b1, `GAM_ADR_THRESH, 32'h0);
		bus(1'b1, `GAM_ADR_THRESH, 32'd101);
		rd(`GAM_ADR_THRESH, 32'hffff, 32'h14);
		bus(1'b1, `GAM_ADR_THRESH, 32'd1);
		rd(`GAM_ADR_THRESH, 32'hffff, 32'd1);
		bus(1'b1, `GAM_ADR_DWELL, 32'd31);
		rd(`GAM_ADR_DWELL, 32'h1f, 32'h0);
		bus(1'b1, `GAM_ADR_DWELL, 32'd30);
		rd(`GAM_ADR_DWELL, 32'h1f, 32'd30);
		bus(1'b1, `GAM_ADR_DWELL, 32'h0);
		bus(1'b1, `GAM_ADR_THRESH, 32'd20);
		bus(1'b1, `GAM_ADR_DEADBAND, 32'd2);
		bus(1'b1, `GAM_ADR_CTRL, 32'h5);
		// random levels below the trip point never raise the alarm
		for (int i = 0; i < 6; i++) begin
			rnd = lfsrNext(rnd);
			upd(rnd % 16'd22);
			check("alarmActive", alarmActive, 1'b0);
		end
		for (int i = 0; i < 5; i++) begin
			upd(hiC[i]);
			check("alarmActive", alarmActive, hiA[i]);
			check("relayOut", relayOut, hiA[i]);
		end
		bus(1'b1, `GAM_ADR_CTRL, 32'h4);
		upd(16'd30);
		check("relayOut", relayOut, 1'b0);
		rd(`GAM_ADR_STATUS, 32'h306, 32'h2);
		// two 20 cycle ticks later the heartbeat must read inverted
		repeat (37) @(posedge clk);
		rd(`GAM_ADR_STATUS, 32'h386, (~rdData & 32'h80) | 32'h2);
		bus(1'b1, `GAM_ADR_CTRL, 32'h7);
		for (int i = 0; i < 6; i++) begin
			upd(loC[i]);
			check("alarmActive", alarmActive, loA[i]);
		end
		// dwell of 3 s with a 20 cycle tick: a short trip is ignored
		bus(1'b1, `GAM_ADR_CTRL, 32'h5);
		upd(16'h0);
		bus(1'b1, `GAM_ADR_DWELL, 32'd3);
		measIn.conc <= 16'd25;
		repeat (12) @(posedge clk);
		upd(16'h0);
		check("alarmActive", alarmActive, 1'b0);
		measIn.conc <= 16'd25;
		repeat (100) @(posedge clk);
		check("alarmActive", alarmActive, 1'b1);
		upd(16'h0);
		// reversal on every update, in step with the far side
		for (int i = 0; i < 20; i++) begin
			repeat (4) @(posedge clk);
			measIn.conc <= i[0] ? 16'd5 : 16'd9;
		end
		rd(`GAM_ADR_FAULTS, 32'h1000, 32'h1000);
		upd(16'h0);
		for (int i = 0; i < 10; i++) begin
			pinsIn <= gam_pins_s'(10'h200 >> i);
			settle();
			rd(`GAM_ADR_FAULTS, 32'h3ffff, 32'h1 << pinBit[i]);
			check("faultActive", faultActive, pinBit[i] < 16);
			check("warnActive", warnActive, pinBit[i] >= 16);
		end
		pinsIn <= '0;
		for (int i = 0; i < 7; i++) begin
			measIn <= '{16'h0, fpT[i], mlT[i], pyT[i]};
			settle();
			rd(`GAM_ADR_FAULTS, 32'h3ffff, fxT[i]);
		end
		// low flow with the check switched off raises nothing
		bus(1'b1, `GAM_ADR_CTRL, 32'h1);
		measIn <= '{16'h0, 16'h0064, 16'd249, 16'd100};
		settle();
		rd(`GAM_ADR_FAULTS, 32'h3ffff, 32'h0);
		wrapUp();
	end
endmodule // gas_alarm_and_fault_monitor_test
